/* File: logic/xlb_pkg.sv */
package xlb_pkg;
  localparam int LANES = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_3 = 8'h7c;
  localparam logic [2:0] SYNC_ACQ_COMMAS = 3'h3;
  localparam logic [2:0] BOND_COLUMNS = 3'h4;
  localparam logic [2:0] MISALIGN_LIMIT = 3'h4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_MASK = 4'h3;
  localparam int CTRL_XAUI = 0;
  localparam int CTRL_GIGABIT_ETHERNET_MODE = 1;
  localparam int CTRL_PLOOP = 2;
  localparam int IRQ_BONDED = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_SYNC = 2;

  typedef struct packed {
    logic [7:0] data;
    logic is_k;
  } xlb_sym_type;

  typedef enum logic [1:0] {
    XLB_HUNT = 2'b00,
    XLB_ALIGN = 2'b01,
    XLB_BONDED = 2'b10
  } xlb_bond_state_type;
endpackage

/* File: logic/xlb_deskew_mem.sv */
`timescale 1ns/1ps
// Per-lane deskew storage; read data leaves through a register.
module xlb_deskew_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk, // Clock.
  input wire logic wr_en, // Write strobe.
  input wire logic [AW-1:0] wr_addr, // Write address.
  input wire xlb_pkg::xlb_sym_type wr_data, // Write symbol.
  input wire logic [AW-1:0] rd_addr, // Read address.
  output xlb_pkg::xlb_sym_type rd_data // Registered read symbol.
);
  xlb_pkg::xlb_sym_type mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: logic/xlb_lane_bond.sv */
`timescale 1ns/1ps
module xlb_lane_bond #(
  parameter int LANES = 4,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // 200 MHz clock.
  input wire logic reset, // Synchronous reset.
  input wire logic [3:0] reg_addr, // Register address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [31:0] reg_rdata, // Read data, next cycle.
  output logic irq, // Level interrupt.
  input wire logic [LANES-1:0] rx_valid, // Decoded data valid per lane.
  input wire xlb_pkg::xlb_sym_type [LANES-1:0] rx_sym, // Decoded symbols.
  input wire xlb_pkg::xlb_sym_type [LANES-1:0] tx_sym, // Transmit symbols.
  input wire logic [LANES-1:0] serial_loopback_sel, // Reverse loopback.
  input wire logic rx_analog_reset, // Receiver analog reset request.
  output xlb_pkg::xlb_sym_type [LANES-1:0] out_sym, // Deskewed symbols.
  output logic out_valid, // Deskewed output valid.
  output logic [LANES-1:0] word_sync, // Comma sync per lane.
  output logic lanes_bonded, // All lanes bonded.
  output logic [LANES-1:0] rx_buffer_pd, // Receive buffer power-down.
  output logic [LANES-1:0] clock_recovery_unit_pd // Recovery unit power-down.
);
  localparam int AW = $clog2(DEPTH);

  logic [2:0] ctrl_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [2:0] nxt_irq_set;
  xlb_pkg::xlb_bond_state_type state_ff;
  xlb_pkg::xlb_bond_state_type nxt_state;
  logic [2:0] col_cnt_ff;
  logic [2:0] mis_cnt_ff;
  logic [LANES-1:0] rsl_s1_ff;
  logic [LANES-1:0] rsl_s2_ff;
  logic ara_s1_ff;
  logic ara_s2_ff;
  logic xaui_en;
  logic gigabit_ethernet_mode_en;
  logic ploop_en;
  logic [LANES-1:0] in_valid;
  xlb_pkg::xlb_sym_type [LANES-1:0] in_sym;
  logic [AW-1:0] wptr_ff [LANES];
  logic [AW-1:0] rptr_ff [LANES];
  logic [LANES-1:0] seen_a_ff;
  xlb_pkg::xlb_sym_type [LANES-1:0] mem_q;
  logic rd_run_ff;
  logic rd_q_valid_ff;
  logic [LANES-1:0] q_is_a;
  logic [LANES-1:0] in_is_a;
  logic all_a;
  logic any_a;
  logic sync_all_prev_ff;
  logic bonded_prev_ff;

  assign xaui_en = ctrl_ff[xlb_pkg::CTRL_XAUI];
  assign gigabit_ethernet_mode_en = ctrl_ff[xlb_pkg::CTRL_GIGABIT_ETHERNET_MODE];
  assign ploop_en = ctrl_ff[xlb_pkg::CTRL_PLOOP];

  // The loopback select and analog reset pins go through two flops before use; rx_valid and rx_sym do not.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rsl_s1_ff <= '0;
      rsl_s2_ff <= '0;
      ara_s1_ff <= 1'b0;
      ara_s2_ff <= 1'b0;
    end else begin
      rsl_s1_ff <= serial_loopback_sel;
      rsl_s2_ff <= rsl_s1_ff;
      ara_s1_ff <= rx_analog_reset;
      ara_s2_ff <= ara_s1_ff;
    end
  end

  // Powering down the front end means nothing can loop back on that lane.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_buffer_pd <= '0;
      clock_recovery_unit_pd <= '0;
    end else begin
      rx_buffer_pd <= rsl_s2_ff & {LANES{ara_s2_ff}};
      clock_recovery_unit_pd <= rsl_s2_ff & {LANES{ara_s2_ff}};
    end
  end

  // Transmit symbols are muxed in combinationally, so no retiming is added.
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      in_sym[i] = ploop_en ? tx_sym[i] : rx_sym[i];
      in_valid[i] = ploop_en ? 1'b1 : rx_valid[i];
      in_is_a[i] = in_valid[i] & in_sym[i].is_k &
        (in_sym[i].data == xlb_pkg::K28_3);
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [2:0] comma_cnt_ff;
      logic comma_hit;
      assign comma_hit = in_valid[g] & in_sym[g].is_k &
        (in_sym[g].data == xlb_pkg::K28_5);

      // Sync is declared after three commas and lost on an invalid symbol.
      always_ff @(posedge sys_clk) begin
        if (reset || !(xaui_en || gigabit_ethernet_mode_en)) begin
          comma_cnt_ff <= '0;
          word_sync[g] <= 1'b0;
        end else if (!in_valid[g]) begin
          comma_cnt_ff <= '0;
          word_sync[g] <= 1'b0;
        end else if (comma_hit && !word_sync[g]) begin
          if (comma_cnt_ff == xlb_pkg::SYNC_ACQ_COMMAS - 3'h1) begin
            word_sync[g] <= 1'b1;
          end
          comma_cnt_ff <= comma_cnt_ff + 3'h1;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (reset || state_ff == xlb_pkg::XLB_HUNT) begin
          wptr_ff[g] <= '0;
          seen_a_ff[g] <= 1'b0;
        end else if (in_valid[g]) begin
          wptr_ff[g] <= wptr_ff[g] + 1'b1;
          if (in_is_a[g] && !seen_a_ff[g] && !rd_run_ff) begin
            seen_a_ff[g] <= 1'b1;
          end
        end
      end

      // Read point holds at the lane's first /A/ until every lane has one.
      always_ff @(posedge sys_clk) begin
        if (reset || state_ff == xlb_pkg::XLB_HUNT) begin
          rptr_ff[g] <= '0;
        end else if (!rd_run_ff) begin
          if (in_valid[g] && in_is_a[g] && !seen_a_ff[g]) begin
            rptr_ff[g] <= wptr_ff[g];
          end
        end else begin
          rptr_ff[g] <= rptr_ff[g] + 1'b1;
        end
      end

      xlb_deskew_mem #(
        .DEPTH(DEPTH),
        .AW(AW)
      ) u_mem (
        .sys_clk(sys_clk),
        .wr_en(in_valid[g] && state_ff != xlb_pkg::XLB_HUNT),
        .wr_addr(wptr_ff[g]),
        .wr_data(in_sym[g]),
        .rd_addr(rptr_ff[g]),
        .rd_data(mem_q[g])
      );

      assign q_is_a[g] = mem_q[g].is_k &
        (mem_q[g].data == xlb_pkg::K28_3);
    end
  endgenerate

  assign all_a = rd_q_valid_ff & (&q_is_a);
  assign any_a = rd_q_valid_ff & (|q_is_a);

  // Reading starts once every lane holds its /A/ at the read point.
  always_ff @(posedge sys_clk) begin
    if (reset || state_ff == xlb_pkg::XLB_HUNT) begin
      rd_run_ff <= 1'b0;
      rd_q_valid_ff <= 1'b0;
    end else begin
      if (&seen_a_ff) begin
        rd_run_ff <= 1'b1;
      end
      rd_q_valid_ff <= rd_run_ff;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      xlb_pkg::XLB_HUNT: begin
        if (xaui_en && (&word_sync)) begin
          nxt_state = xlb_pkg::XLB_ALIGN;
        end
      end
      xlb_pkg::XLB_ALIGN: begin
        if (all_a && col_cnt_ff == xlb_pkg::BOND_COLUMNS - 3'h1) begin
          nxt_state = xlb_pkg::XLB_BONDED;
        end
      end
      xlb_pkg::XLB_BONDED: begin
        if (any_a && !all_a &&
            mis_cnt_ff == xlb_pkg::MISALIGN_LIMIT - 3'h1) begin
          nxt_state = xlb_pkg::XLB_HUNT;
        end
      end
      default: nxt_state = xlb_pkg::XLB_HUNT;
    endcase
    if (!xaui_en || !(&word_sync)) begin
      nxt_state = xlb_pkg::XLB_HUNT;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= xlb_pkg::XLB_HUNT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // A misaligned column in the aligning phase is ignored; only aligned columns advance col_cnt_ff.
  always_ff @(posedge sys_clk) begin
    if (reset || state_ff != xlb_pkg::XLB_ALIGN) begin
      col_cnt_ff <= '0;
    end else if (all_a) begin
      col_cnt_ff <= col_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || state_ff != xlb_pkg::XLB_BONDED) begin
      mis_cnt_ff <= '0;
    end else if (all_a) begin
      mis_cnt_ff <= '0;
    end else if (any_a) begin
      mis_cnt_ff <= mis_cnt_ff + 3'h1;
    end
  end

  assign lanes_bonded = (state_ff == xlb_pkg::XLB_BONDED);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_sym <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= xaui_en ? rd_q_valid_ff : (&in_valid);
      for (int i = 0; i < LANES; i++) begin
        out_sym[i] <= xaui_en ? mem_q[i] : in_sym[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bonded_prev_ff <= 1'b0;
      sync_all_prev_ff <= 1'b0;
    end else begin
      bonded_prev_ff <= lanes_bonded;
      sync_all_prev_ff <= &word_sync;
    end
  end

  always_comb begin
    nxt_irq_set = '0;
    nxt_irq_set[xlb_pkg::IRQ_BONDED] = lanes_bonded & ~bonded_prev_ff;
    nxt_irq_set[xlb_pkg::IRQ_LOST] = ~lanes_bonded & bonded_prev_ff;
    nxt_irq_set[xlb_pkg::IRQ_SYNC] = (&word_sync) & ~sync_all_prev_ff;
  end

  // Loopback choice is latched only while no mode is running.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_ff <= '0;
    end else if (reg_wr && reg_addr == xlb_pkg::REG_CTRL) begin
      ctrl_ff[xlb_pkg::CTRL_XAUI] <= reg_wdata[xlb_pkg::CTRL_XAUI];
      ctrl_ff[xlb_pkg::CTRL_GIGABIT_ETHERNET_MODE] <= reg_wdata[xlb_pkg::CTRL_GIGABIT_ETHERNET_MODE];
      if (!xaui_en && !gigabit_ethernet_mode_en) begin
        ctrl_ff[xlb_pkg::CTRL_PLOOP] <= reg_wdata[xlb_pkg::CTRL_PLOOP];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_mask_ff <= '0;
    end else if (reg_wr && reg_addr == xlb_pkg::REG_IRQ_MASK) begin
      irq_mask_ff <= reg_wdata[2:0];
    end
  end

  // A new event wins over a same-cycle write-one clear.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_stat_ff <= '0;
    end else if (reg_wr && reg_addr == xlb_pkg::REG_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata[2:0]) | nxt_irq_set;
    end else begin
      irq_stat_ff <= irq_stat_ff | nxt_irq_set;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        xlb_pkg::REG_CTRL: reg_rdata <= {29'h0, ctrl_ff};
        xlb_pkg::REG_STATUS: reg_rdata <= {23'h0, rx_buffer_pd, word_sync,
          lanes_bonded};
        xlb_pkg::REG_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_ff};
        xlb_pkg::REG_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_ff};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  a_bond_flag_reset: assert property (@(posedge sys_clk)
    reset |=> !lanes_bonded)
    else $error("bonded flag high after reset");

  a_bond_xaui_only: assert property (@(posedge sys_clk)
    disable iff (reset) lanes_bonded |-> $past(xaui_en))
    else $error("bonded outside xaui mode");

  a_bond_needs_cols: assert property (@(posedge sys_clk)
    disable iff (reset)
    $rose(lanes_bonded) |-> $past(all_a) && $past(col_cnt_ff) == 3'h3)
    else $error("bonded without four aligned columns");

  a_bond_lost_mis: assert property (@(posedge sys_clk)
    disable iff (reset)
    (lanes_bonded && any_a && !all_a && mis_cnt_ff == 3'h3 &&
     xaui_en && (&word_sync)) |=> !lanes_bonded)
    else $error("flag kept after four misaligned columns");

  a_bond_restart: assert property (@(posedge sys_clk)
    disable iff (reset) $fell(lanes_bonded) |->
      state_ff == xlb_pkg::XLB_HUNT ##1 !rd_run_ff)
    else $error("alignment not restarted");

  a_ploop_route: assert property (@(posedge sys_clk) disable iff (reset)
    (ploop_en && !xaui_en) |=> out_sym == $past(tx_sym) && out_valid)
    else $error("loopback path not digital transmit data");

  a_ploop_static: assert property (@(posedge sys_clk)
    disable iff (reset) (xaui_en || gigabit_ethernet_mode_en) |=> $stable(ploop_en))
    else $error("loopback changed during operation");

  a_pd_follow: assert property (@(posedge sys_clk) disable iff (reset)
    (ara_s2_ff && rsl_s2_ff[0]) |=> rx_buffer_pd[0] &&
      clock_recovery_unit_pd[0])
    else $error("front end not powered down");

  a_sync_needs_mode: assert property (@(posedge sys_clk)
    disable iff (reset)
    !(xaui_en || gigabit_ethernet_mode_en) |=> word_sync == '0)
    else $error("word sync without mode");
endmodule

/* File: dv/xlb_link_partner.sv */
`timescale 1ns/1ps
// Far-end lanes; lane i lags lane 0 by i words, so the block must deskew.
module xlb_link_partner (
  input wire logic sys_clk, // Clock.
  input wire logic [1:0] mode, // 0 idle, 1 commas, 2 /A/ all, 3 /A/ lane 0.
  output logic [3:0] rx_valid, // Lane valid.
  output xlb_pkg::xlb_sym_type [3:0] rx_sym // Lane symbols.
);
  logic [7:0] cnt_ff = 8'h00;

  always_ff @(posedge sys_clk) begin
    cnt_ff <= cnt_ff + 8'h01;
    for (int i = 0; i < 4; i++) begin
      rx_valid[i] <= (mode != 2'h0);
      if (mode == 2'h1) begin
        rx_sym[i] <= '{data: xlb_pkg::K28_5, is_k: 1'b1};
      end else if (mode[1] && cnt_ff[2:0] == 3'(i) &&
                   (!mode[0] || i == 0)) begin
        rx_sym[i] <= '{data: xlb_pkg::K28_3, is_k: 1'b1};
      end else begin
        // Idle lanes still toggle so stale data is never mistaken for valid.
        rx_sym[i] <= '{data: cnt_ff ^ 8'h55, is_k: 1'b0};
      end
    end
  end
endmodule

/* File: dv/xlb_lane_bond_tb.sv */
`timescale 1ns/1ps
module xlb_lane_bond_tb;
  localparam xlb_pkg::xlb_sym_type A_SYM = '{xlb_pkg::K28_3, 1'b1};
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  logic [3:0] rx_valid;
  xlb_pkg::xlb_sym_type [3:0] rx_sym;
  xlb_pkg::xlb_sym_type [3:0] tx_sym = '0;
  logic [3:0] serial_loopback_sel = 4'h0;
  logic rx_analog_reset = 1'b0;
  xlb_pkg::xlb_sym_type [3:0] out_sym;
  logic out_valid;
  logic [3:0] word_sync;
  logic lanes_bonded;
  logic [3:0] rx_buffer_pd;
  logic [3:0] clock_recovery_unit_pd;
  logic [1:0] mode = 2'h0;
  int miscompares = 0;
  int checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;

  xlb_lane_bond #(.LANES(4), .DEPTH(16)) dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq(irq),
    .rx_valid(rx_valid),
    .rx_sym(rx_sym),
    .tx_sym(tx_sym),
    .serial_loopback_sel(serial_loopback_sel),
    .rx_analog_reset(rx_analog_reset),
    .out_sym(out_sym),
    .out_valid(out_valid),
    .word_sync(word_sync),
    .lanes_bonded(lanes_bonded),
    .rx_buffer_pd(rx_buffer_pd),
    .clock_recovery_unit_pd(clock_recovery_unit_pd)
  );

  xlb_link_partner partner (
    .sys_clk(sys_clk),
    .mode(mode),
    .rx_valid(rx_valid),
    .rx_sym(rx_sym)
  );

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [35:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp,
                          input string name);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, 36'(exp), 36'(reg_rdata));
  endtask

  // Bounded wait; running out is a mismatch and ends the run.
  task automatic wait_bond(input logic lvl, input int lim);
    int n = 0;
    while (lanes_bonded !== lvl) begin
      ticks(1);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("[ERR] lanes_bonded expected %0b seen %0b timed out", lvl,
                 lanes_bonded);
        complete_run();
      end
    end
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("lanes_bonded", 36'h0, 36'(lanes_bonded));
    chk("irq", 36'h0, 36'(irq));
    reg_read(xlb_pkg::REG_CTRL, 32'h0, "ctrl");
    reg_read(4'h7, 32'h0, "unmapped");
    reg_write(xlb_pkg::REG_CTRL, 32'h2);
    mode <= 2'h1;
    ticks(6);
    chk("word_sync", 36'hf, 36'(word_sync));
    @(posedge sys_clk);
    mode <= 2'h2;
    ticks(60);
    chk("lanes_bonded", 36'h0, 36'(lanes_bonded));
    reg_read(xlb_pkg::REG_STATUS, 32'h1e, "status");
    reg_write(xlb_pkg::REG_CTRL, 32'h1);
    wait_bond(1'b1, 200);
    for (int n = 0; n < 20 && out_sym[0] !== A_SYM; n++) begin
      ticks(1);
    end
    chk("a_column", {4{A_SYM}}, 36'(out_sym));
    reg_read(xlb_pkg::REG_STATUS, 32'h1f, "status");
    reg_read(xlb_pkg::REG_IRQ_STAT, 32'h5, "irq_stat");
    chk("irq", 36'h0, 36'(irq));
    reg_write(xlb_pkg::REG_IRQ_MASK, 32'h1);
    reg_read(xlb_pkg::REG_IRQ_MASK, 32'h1, "irq_mask");
    ticks(1);
    chk("irq", 36'h1, 36'(irq));
    reg_write(xlb_pkg::REG_IRQ_STAT, 32'h1);
    ticks(1);
    chk("irq", 36'h0, 36'(irq));
    // Only lane 0 keeps /A/; one misaligned column must not yet drop it.
    @(posedge sys_clk);
    mode <= 2'h3;
    ticks(12);
    chk("lanes_bonded", 36'h1, 36'(lanes_bonded));
    wait_bond(1'b0, 80);
    reg_read(xlb_pkg::REG_IRQ_STAT, 32'h6, "irq_stat");
    @(posedge sys_clk);
    mode <= 2'h2;
    wait_bond(1'b1, 200);
    reg_write(xlb_pkg::REG_CTRL, 32'h5);
    reg_read(xlb_pkg::REG_CTRL, 32'h1, "ctrl");
    reg_write(xlb_pkg::REG_CTRL, 32'h0);
    reg_write(xlb_pkg::REG_CTRL, 32'h4);
    reg_read(xlb_pkg::REG_CTRL, 32'h4, "ctrl");
    @(posedge sys_clk);
    tx_sym <= 36'h123456789;
    ticks(4);
    chk("out_sym", 36'h123456789, 36'(out_sym));
    chk("out_valid", 36'h1, 36'(out_valid));
    chk("lanes_bonded", 36'h0, 36'(lanes_bonded));
    @(posedge sys_clk);
    serial_loopback_sel <= 4'h5;
    ticks(5);
    chk("rx_buffer_pd", 36'h0, 36'(rx_buffer_pd));
    @(posedge sys_clk);
    rx_analog_reset <= 1'b1;
    ticks(5);
    chk("rx_buffer_pd", 36'h5, 36'(rx_buffer_pd));
    chk("cru_pd", 36'h5, 36'(clock_recovery_unit_pd));
    @(posedge sys_clk);
    serial_loopback_sel <= 4'ha;
    ticks(5);
    chk("cru_pd", 36'ha, 36'(clock_recovery_unit_pd));
    @(posedge sys_clk);
    rx_analog_reset <= 1'b0;
    ticks(5);
    chk("rx_buffer_pd", 36'h0, 36'(rx_buffer_pd));
    complete_run();
  end
endmodule
